// File: sync_sram.sv
// Notes on behaviour
// - Load captures address; data two cycles later
// - Advance high increments burst counter, internal address
// - Burst advance ignores read/write select
// - Loaded direction fixes whole burst direction
// - Any select false with load starts deselect
// - Deselect floats bus two cycles later
// - Clock gate high: edge has no effect
// - Suspend holds all registers and pin values; output enable can still float the pins
// - Selected only when all three selects true
// - Data outputs float from first edge on
// - All enables low write all; high none
// - Each enable gates one nine-bit lane
// - Any enable combination writes lanes independently
// - Narrow configuration uses only two enables
// - Order select picks interleaved or linear sequence
// - Two-bit counter wraps after fourth beat
// - Output enable high floats the data pins
`timescale 1ns/1ps
`default_nettype none

module write_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  assign in_ready = st.count != DEPTH[PW:0];
  assign out_valid = st.count != '0;
  assign out_data = store[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.count = st.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    if (rst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
    if (push) begin
      store[st.wr] <= in_data;
    end
  end
endmodule : write_fifo

module sync_sram
  import sram_pkg::*;
#(
  parameter int NUM_LANES = MAX_LANES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_gate_n,
  input wire logic advance_or_load,
  input wire logic read_write_n,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [MAX_LANES-1:0] byte_write_n,
  input wire logic burst_order_sel,
  input wire logic output_enable_n,
  input wire logic [PIN_W-1:0] data_lines_in,
  input wire logic [MAX_LANES-1:0] parity_lines_in,
  output logic [PIN_W-1:0] data_lines_out,
  output logic [MAX_LANES-1:0] parity_lines_out,
  output logic data_oe
);
  typedef struct packed {
    burst_t mode;
    logic [ADDR_W-1:0] base;
    logic [1:0] cnt;
    stage_t s1;
    stage_t s2;
    logic [DATA_W-1:0] dq;
    logic drive;
  } core_t;

  core_t st;
  core_t next_st;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic en;
  logic sel;
  logic fifo_in_ready;
  logic head_valid;
  logic [ENTRY_W-1:0] head_bits;
  wr_entry_t head;
  wr_entry_t push_entry;
  logic push;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] pin_word;
  logic [1:0] next_cnt;
  logic [1:0] low_bits;

  assign en = !clock_gate_n && fifo_in_ready;
  assign sel = !chip_sel_a_n && !chip_sel_c_n && chip_sel_b;
  assign head = wr_entry_t'(head_bits);
  assign next_cnt = st.cnt + CNT_STEP;

  // Burst low address bits from the loaded start and beat count
  always_comb begin
    if (burst_order_sel == BURST_INTERLEAVED) begin
      low_bits = st.base[1:0] ^ next_cnt;
    end else begin
      low_bits = st.base[1:0] + next_cnt;
    end
  end

  // Pin lanes to internal lanes, with a forward from the draining head
  always_comb begin
    rd_word = mem[st.s2.addr];
    pin_word = '0;
    push_entry = '0;
    for (int i = 0; i < MAX_LANES; i++) begin
      pin_word[i*LANE_W +: LANE_W] = {parity_lines_in[i], data_lines_in[i*BYTE_W +: BYTE_W]};
      push_entry.lane_en[i] = !st.s2.byte_write_n[i] && (i < NUM_LANES);
      if (head_valid && head.lane_en[i] && head.addr == st.s2.addr) begin
        rd_word[i*LANE_W +: LANE_W] = head.data[i*LANE_W +: LANE_W];
      end
    end
    push_entry.addr = st.s2.addr;
    push_entry.data = pin_word;
  end

  always_comb begin
    next_st = st;
    push = 1'b0;
    if (en) begin
      next_st.s2 = st.s1;
      next_st.s1 = '0;
      if (!advance_or_load) begin
        if (sel) begin
          next_st.mode = read_write_n ? burst_read : burst_write;
          next_st.base = address;
          next_st.cnt = CNT_START;
          next_st.s1.valid = 1'b1;
          next_st.s1.write = !read_write_n;
          next_st.s1.addr = address;
          next_st.s1.byte_write_n = byte_write_n;
        end else begin
          next_st.mode = burst_none;
        end
      end else begin
        case (st.mode)
          burst_read, burst_write: begin
            next_st.cnt = next_cnt;
            next_st.s1.valid = 1'b1;
            next_st.s1.write = st.mode == burst_write;
            next_st.s1.addr = {st.base[ADDR_W-1:2], low_bits};
            next_st.s1.byte_write_n = byte_write_n;
          end
          default: begin
            next_st.mode = burst_none;
          end
        endcase
      end
      if (st.s2.valid && !st.s2.write) begin
        next_st.dq = rd_word;
        next_st.drive = 1'b1;
      end else begin
        next_st.drive = 1'b0;
      end
      push = st.s2.valid && st.s2.write;
    end
    if (rst) begin
      next_st = '0;
      next_st.mode = burst_none;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Write commits drain only while the pipeline runs
  write_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH)
  ) write_fifo_inst (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(head_valid),
    .out_ready(en),
    .out_data(head_bits)
  );

  always_ff @(posedge clk) begin
    if (head_valid && en) begin
      for (int i = 0; i < MAX_LANES; i++) begin
        if (head.lane_en[i]) begin
          mem[head.addr][i*LANE_W +: LANE_W] <= head.data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < MAX_LANES; i++) begin
      data_lines_out[i*BYTE_W +: BYTE_W] = st.dq[i*LANE_W +: BYTE_W];
      parity_lines_out[i] = st.dq[i*LANE_W + BYTE_W];
    end
  end

  // Asynchronous float overrides the registered drive
  assign data_oe = st.drive && !output_enable_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_read_latency: assert property (
    (en && !advance_or_load && sel && read_write_n) ##1 en ##1 en |=> st.drive
  ) else $error("read load did not drive two cycles later");

  chk_burst_count: assert property (
    (en && advance_or_load && st.mode != burst_none) |=> st.cnt == $past(st.cnt) + 2'h1
  ) else $error("burst counter did not advance");

  chk_burst_dir: assert property (
    (en && advance_or_load && st.mode == burst_write) |=> st.s1.valid && st.s1.write
  ) else $error("burst beat lost the loaded direction");

  chk_desel_stage: assert property (
    (en && !advance_or_load && !sel) |=> !st.s1.valid && st.mode == burst_none
  ) else $error("deselect still started an access");

  chk_desel_float: assert property (
    (en && !advance_or_load && !sel) ##1 en ##1 en |=> !st.drive
  ) else $error("bus not floated two cycles after deselect");

  chk_suspend_hold: assert property (
    clock_gate_n |=> $stable(st)
  ) else $error("state changed during suspend");

  chk_select_all: assert property (
    (en && !advance_or_load && (chip_sel_a_n || chip_sel_c_n || !chip_sel_b)) |=> !st.s1.valid
  ) else $error("partial select accepted");

  chk_reset_float: assert property (
    disable iff (1'b0) rst |=> !data_oe
  ) else $error("outputs driven after reset");

  chk_lane_mask: assert property (
    push |-> push_entry.lane_en[0] == !st.s2.byte_write_n[0]
  ) else $error("lane enable does not follow byte write");

  chk_linear_seq: assert property (
    (en && advance_or_load && st.mode != burst_none && !burst_order_sel)
      |=> st.s1.addr[1:0] == $past(st.base[1:0]) + st.cnt
  ) else $error("linear burst address wrong");

  chk_idle_beat: assert property (
    (en && advance_or_load && st.mode == burst_none) |=> !st.s1.valid
  ) else $error("idle cycle started an access");

  chk_oe_float: assert property (
    output_enable_n |-> !data_oe
  ) else $error("pins driven with output enable high");

  chk_reset_idle: assert property (
    disable iff (1'b0) rst |=> !st.s1.valid && !st.s2.valid && st.mode == burst_none
  ) else $error("pipeline not empty after reset");

  chk_load_capture: assert property (
    (en && !advance_or_load && sel) |=> st.s1.valid && st.s1.addr == $past(address)
      && st.s1.write == !$past(read_write_n)
  ) else $error("load did not capture address and direction");

  chk_read_no_push: assert property (
    (st.s2.valid && !st.s2.write) |-> !push
  ) else $error("read beat queued a write");

  chk_write_no_drive: assert property (
    (en && st.s2.valid && st.s2.write) |=> !st.drive
  ) else $error("write beat drove the data pins");

  chk_burst_upper: assert property (
    (en && advance_or_load && st.mode != burst_none) |=> st.s1.addr[ADDR_W-1:2] == $past(st.base[ADDR_W-1:2])
  ) else $error("burst left its four-word block");

  chk_read_dir: assert property (
    (en && advance_or_load && st.mode == burst_read) |=> st.s1.valid && !st.s1.write
  ) else $error("read burst beat turned into a write");

  chk_gate_ignored: assert property (
    (clock_gate_n && !advance_or_load) |=> st.s1 == $past(st.s1) && st.mode == $past(st.mode)
  ) else $error("suspended edge took a load");

  chk_pins_hold: assert property (
    clock_gate_n |=> $stable(data_lines_out) && $stable(parity_lines_out)
  ) else $error("pins changed during suspend");

  chk_all_lanes: assert property (
    (push && st.s2.byte_write_n == '0) |-> push_entry.lane_en == ({MAX_LANES{1'b1}} >> (MAX_LANES - NUM_LANES))
  ) else $error("all-lane write lost a lane");

  chk_no_lanes: assert property (
    (push && &st.s2.byte_write_n) |-> push_entry.lane_en == '0
  ) else $error("masked write enabled a lane");

  chk_narrow_lanes: assert property (
    push |-> (push_entry.lane_en >> NUM_LANES) == '0
  ) else $error("absent lane enabled");

  chk_interleave_seq: assert property (
    (en && advance_or_load && st.mode != burst_none && burst_order_sel)
      |=> st.s1.addr[1:0] == ($past(st.base[1:0]) ^ st.cnt)
  ) else $error("interleaved burst address wrong");

  chk_burst_wrap: assert property (
    (en && advance_or_load && st.mode != burst_none && st.cnt == 2'h3)
      |=> st.cnt == CNT_START && st.s1.addr[1:0] == st.base[1:0]
  ) else $error("burst counter did not wrap to start");

  cov_burst_read: cover property (
    (en && st.mode == burst_read && advance_or_load) [*3]
  );
  cov_write_push: cover property (push && push_entry.lane_en != '0);
  cov_suspend_read: cover property (clock_gate_n && st.drive);
  cov_interleave_burst: cover property (en && advance_or_load && st.mode == burst_read && burst_order_sel);
  cov_deselect_float: cover property ((en && !advance_or_load && !sel) ##1 en ##1 en);
endmodule : sync_sram
`default_nettype wire

// File: sram_pkg.sv
`default_nettype none
package sram_pkg;
  localparam int ADDR_W = 18;
  localparam int LANE_W = 9;
  localparam int BYTE_W = 8;
  localparam int MAX_LANES = 4;
  localparam int DATA_W = LANE_W * MAX_LANES;
  localparam int PIN_W = BYTE_W * MAX_LANES;
  localparam int FIFO_DEPTH = 16;
  localparam int PIPE_LAT = 2;
  localparam logic [1:0] CNT_START = 2'h0;
  localparam logic [1:0] CNT_STEP = 2'h1;
  localparam logic BURST_INTERLEAVED = 1'h1;

  typedef enum logic [1:0] {
    burst_none,
    burst_read,
    burst_write
  } burst_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [MAX_LANES-1:0] byte_write_n;
  } stage_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [MAX_LANES-1:0] lane_en;
  } wr_entry_t;

  localparam int ENTRY_W = $bits(wr_entry_t);
endpackage : sram_pkg
`default_nettype wire

// File: bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
  import sram_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_gate_n,
  input wire logic wr_beat,
  input wire logic [DATA_W-1:0] wr_word,
  input wire logic [MAX_LANES-1:0] wr_mask,
  output logic [PIN_W-1:0] data_lines_in,
  output logic [MAX_LANES-1:0] parity_lines_in,
  output logic [MAX_LANES-1:0] byte_write_n
);
  logic [DATA_W:0] s1;
  logic [DATA_W:0] s2;
  logic [DATA_W-1:0] last;
  // Write data trails its beat by two enabled edges
  always @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      last <= '0;
    end else if (!clock_gate_n) begin
      s2 <= s1;
      s1 <= {wr_beat, wr_word};
      if (s2[DATA_W]) last <= s2[DATA_W-1:0];
    end
  end
  // Lane enables go out with the beat itself, not with its data
  assign byte_write_n = wr_beat ? wr_mask : {MAX_LANES{1'b1}};
  always_comb begin
    if (s2[DATA_W]) begin
      {parity_lines_in, data_lines_in} = s2[DATA_W-1:0];
    end else begin
      // Released bus shows the inverse of the last word
      {parity_lines_in, data_lines_in} = ~last;
    end
  end
endmodule : bus_master_model
`default_nettype wire

// File: sync_sram_test.sv
`timescale 1ns/1ps
`default_nettype none
module sync_sram_test;
  import sram_pkg::*;
  localparam logic [2:0] SEL = 3'h2;
  logic clk = 0, rst = 1, gate_n = 0, adv = 1, rw = 1, bos = 0, oe_n = 0, wb = 0, oe;
  logic [2:0] sel = 3'h2;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] word = '0;
  logic [MAX_LANES-1:0] mask = 4'hf, pin, pout, bwn;
  logic [PIN_W-1:0] din, dout;
  int failures = 0, samples_checked = 0, cycles = 0;
  always #2 clk = ~clk;
  sync_sram #(.NUM_LANES(MAX_LANES), .DEPTH(FIFO_DEPTH)) sync_sram_inst (.clk(clk), .rst(rst),
    .clock_gate_n(gate_n), .advance_or_load(adv), .read_write_n(rw), .chip_sel_a_n(sel[2]),
    .chip_sel_b(sel[1]), .chip_sel_c_n(sel[0]), .address(addr), .byte_write_n(bwn),
    .burst_order_sel(bos), .output_enable_n(oe_n), .data_lines_in(din), .parity_lines_in(pin),
    .data_lines_out(dout), .parity_lines_out(pout), .data_oe(oe));
  bus_master_model bus_master_model_inst (.clk(clk), .rst(rst), .clock_gate_n(gate_n), .wr_beat(wb),
    .wr_word(word), .wr_mask(mask), .data_lines_in(din), .parity_lines_in(pin), .byte_write_n(bwn));
  function automatic logic [DATA_W-1:0] w(input int k);
    return {4'(k) ^ 4'ha, {4{8'(k * 17)}}};
  endfunction : w
  task final_report();
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task chk(input logic e_oe, input logic [DATA_W-1:0] e);
    samples_checked++;
    if (oe !== e_oe || (e_oe && {pout, dout} !== e)) begin
      failures++;
      $display("wrong value at %0t: oe %b data %h, want %b %h", $time, oe, {pout, dout}, e_oe, e);
    end
  endtask : chk
  task beat(input logic a, input logic r, input logic [2:0] s, input logic [ADDR_W-1:0] ad,
            input logic b, input logic [DATA_W-1:0] d, input logic [MAX_LANES-1:0] m);
    @(posedge clk);
    adv <= a;
    rw <= r;
    sel <= s;
    addr <= ad;
    wb <= b;
    word <= d;
    mask <= m;
    #1;
  endtask : beat
  // Five-beat read burst, then deselect and idle beats
  task burst_rd(input logic [ADDR_W-1:0] a, input logic [7:0] ord, input logic [2:0] ds);
    for (int k = 0; k < 10; k++) begin
      if (k < 5) beat(k != 0, k == 0, SEL, a, 0, '0, 4'hf);
      else beat(k > 5, 0, ds, '0, 0, '0, 4'h0);
      if (k >= 3 && k < 8) chk(1, w(ord[2 * ((k - 3) % 4) +: 2]));
      else if (k >= 8) chk(0, '0);
    end
    $display("test burst read at %0h done", a);
  endtask : burst_rd
  always @(posedge clk) begin
    cycles++;
    if (cycles > 1000) begin
      failures++;
      $display("wrong value at %0t: timeout", $time);
      final_report();
    end
  end
  task reset_float();
    beat(1, 1, SEL, '0, 0, '0, 4'hf);
    chk(0, '0);
    $display("test reset float done");
  endtask : reset_float
  // Four-beat linear write burst; the bus stays floated throughout
  task write_burst();
    for (int k = 0; k < 4; k++) begin
      beat(k != 0, k != 0, SEL, 18'h2, 1, w(k), 4'h0);
      chk(0, '0);
    end
    $display("test write burst done");
  endtask : write_burst
  // Three writes to one word with different lane masks, then read back
  task byte_lanes();
    beat(0, 0, SEL, 18'h5, 1, w(9), 4'h0);
    beat(0, 0, SEL, 18'h5, 1, w(10), 4'ha);
    beat(0, 0, SEL, 18'h5, 1, w(11), 4'hf);
    beat(0, 1, SEL, 18'h5, 0, '0, 4'hf);
    repeat (3) beat(0, 0, 3'h6, '0, 0, '0, 4'h0);
    chk(1, (w(10) & 36'h500ff00ff) | (w(9) & ~36'h500ff00ff));
    $display("test byte lanes done");
  endtask : byte_lanes
  // Read burst frozen by the clock gate, with an output float inside
  task suspend_read();
    beat(0, 1, SEL, 18'h2, 0, '0, 4'hf);
    beat(1, 0, SEL, '0, 0, '0, 4'h0);
    beat(0, 0, 3'h6, '0, 0, '0, 4'h0);
    beat(0, 0, 3'h6, '0, 0, '0, 4'h0);
    chk(1, w(0));
    @(posedge clk);
    gate_n <= 1;
    #1;
    chk(1, w(1));
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      oe_n <= i == 1;
      gate_n <= i < 3;
      #1;
      chk(i != 1, w(1));
    end
    @(posedge clk);
    #1;
    chk(0, '0);
    $display("test suspend done");
  endtask : suspend_read
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    reset_float();
    write_burst();
    burst_rd(18'h2, 8'he4, 3'h6);
    @(posedge clk);
    bos <= 1;
    burst_rd(18'h1, 8'h1b, 3'h0);
    @(posedge clk);
    bos <= 0;
    burst_rd(18'h3, 8'h39, 3'h3);
    byte_lanes();
    suspend_read();
    final_report();
  end
endmodule : sync_sram_test
`default_nettype wire
